// >>> pkg/i2cc_consts.svh
// constants for the two-wire bus controller
`ifndef I2CC_CONSTS_SVH
`define I2CC_CONSTS_SVH
`define I2CC_SYS_CLK_KHZ 40000
`define I2CC_SCL_KHZ 100
`define I2CC_CNT_W 16
`define I2CC_BASE_ADDR 16'h0010
`define I2CC_SYNC_INIT 5'h1F
`define I2CC_BIT_FIRST 4'h0
`define I2CC_BIT_LAST 4'h7
`define I2CC_BIT_ACK 4'h8
`define I2CC_BIT_PRE 4'hF
`endif

// >>> pkg/i2cc_pkg.sv
// types for the two-wire bus controller
`include "i2cc_consts.svh"
package i2cc_pkg;
  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_XFER, H_ACK} i2cc_host_st_t;
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_HOLD, M_STOP1, M_STOP2, M_RS1, M_RS2
  } i2cc_mst_st_t;
  typedef struct packed {
    i2cc_host_st_t hs;
    i2cc_mst_st_t ms;
    logic [`I2CC_CNT_W-1:0] cnt;
    logic [3:0] bitcnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [7:0] dout;
    logic dout_oe;
    logic active;
    logic addr_ph;
    logic is_master;
    logic addressed;
    logic xmit;
    logic rw_bit;
    logic rx_nack;
    logic busy;
    logic byte_done;
    logic go;
    logic arb_flag;
    logic hit_flag;
    logic sda_drv;
    logic scl_p;
    logic sda_p;
  } i2cc_state_t;
endpackage

// >>> logic/i2cc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module i2cc_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] stable
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } i2cc_sync_state_t;

  i2cc_sync_state_t st_reg;
  i2cc_sync_state_t st_next;

  // s1 feeds s2 only; a bit moves once s2 and s3 agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.q = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 ^ st_reg.s3)); // RULE24
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= {INIT, INIT, INIT, INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign stable = st_reg.q;

  a_sync_agree: assert property (@(posedge clock) disable iff (!reset_n) // RULE24
    (st_reg.s2 == st_reg.s3) |=> (st_reg.q == $past(st_reg.s3)))
    else $error("synchroniser output ignored agreeing stages");
endmodule

// >>> logic/i2cc_ctrl.sv
// two-wire bus controller: host strobe port plus master/slave byte engine
`timescale 1ns/1ps
`include "i2cc_consts.svh"
// Overview of operation
// RULE1 - start is data falling while clock high; detected here as start
// RULE2 - stop is data rising while clock high; detected here as stop
// RULE3 - data changes only while clock is low, stable during clock high
// RULE4 - each byte is eight data bits plus one acknowledge, nine clocks
// RULE5 - bits go out and come in most significant first
// RULE6 - transmitter releases data in acknowledge slot, accepting receiver pulls low
// RULE7 - master transmitter ends with stop when slave does not acknowledge
// RULE8 - master receiver not acknowledging ends slave transmitter, which releases data
// RULE9 - first byte is seven-bit address plus direction, one means read
// RULE10 - only matching slave answers, pulling data low in ninth clock
// RULE11 - master can issue repeated start, frees bus only with stop
// RULE12 - lost arbitration flags the host and falls back to slave
// RULE13 - own address called flags the host and enters slave operation
// RULE14 - software picks acknowledge or not-acknowledge when receiving
// RULE15 - bus free when both lines high, busy from start to stop
// RULE16 - host drives low address strobe when its address is valid
// RULE17 - host drives low data strobe for write data or read turnaround
// RULE18 - host drives direction high to read, low to write
// RULE19 - transfer acknowledge low once read data valid or write data taken
// RULE20 - pending events reach host on a low interrupt request
// RULE21 - byte-done clears during a byte, sets on ninth clock falling
// RULE22 - clock divider yields 100 kHz, recomputed from system clock rate
// RULE23 - both strobes negated after acknowledge drops acknowledge, back to idle
// RULE24 - serial lines are synchronised before any edge or condition detection
module i2cc_ctrl
  import i2cc_pkg::*;
#(
  parameter int CLK_KHZ = `I2CC_SYS_CLK_KHZ,
  parameter int SCL_KHZ = `I2CC_SCL_KHZ,
  parameter logic [15:0] BASE_ADDR = `I2CC_BASE_ADDR
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [23:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  output logic transfer_ack_n,
  output logic irq_n,
  output logic byte_done_flag,
  input wire logic master_sel,
  input wire logic repeat_start,
  input wire logic ack_disable,
  input wire logic [6:0] own_addr,
  input wire logic irq_enable,
  input wire logic flag_clear,
  output logic bus_busy,
  output logic master_mode,
  output logic slave_addressed,
  output logic slave_read,
  output logic arb_lost,
  output logic addressed_hit,
  output logic rx_nack
);
  // half of one serial clock period; scales with the system clock rate
  localparam int HALF = CLK_KHZ / (2 * SCL_KHZ); // RULE22
  localparam logic [`I2CC_CNT_W-1:0] HALF_M1 = `I2CC_CNT_W'(HALF - 1);
  localparam i2cc_state_t RESET_ST = '{hs: H_IDLE, ms: M_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};

  i2cc_state_t st_reg;
  i2cc_state_t st_next;
  logic [4:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic as_s;
  logic ds_s;
  logic rw_s;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic arb_hit;
  logic half_done;

  // strobes and serial lines all come from other clock domains
  i2cc_sync #(.W(5), .INIT(`I2CC_SYNC_INIT)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({scl_in, sda_in, address_strobe_n, data_strobe_n, read_write}),
    .stable(sync_q)
  );
  assign {scl_s, sda_s, as_s, ds_s, rw_s} = sync_q; // RULE24

  assign rise = scl_s & ~st_reg.scl_p;
  assign fall = ~scl_s & st_reg.scl_p;
  assign start_det = scl_s & st_reg.scl_p & st_reg.sda_p & ~sda_s; // RULE1
  assign stop_det = scl_s & st_reg.scl_p & ~st_reg.sda_p & sda_s; // RULE2
  // a released one bit read back as zero means another master won
  assign arb_hit = st_reg.is_master & st_reg.active & st_reg.xmit & rise & ~st_reg.bitcnt[3] &
                   ~st_reg.sda_drv & ~sda_s; // RULE12
  assign half_done = (st_reg.cnt == HALF_M1);

  always_comb begin
    st_next = st_reg;
    st_next.scl_p = scl_s;
    st_next.sda_p = sda_s;
    // clear first so that a flag set in the same cycle survives
    if (flag_clear) begin
      st_next.arb_flag = 1'b0;
      st_next.hit_flag = 1'b0;
    end

    // byte engine, shared by master and slave operation
    if (start_det) begin
      st_next.busy = 1'b1; // RULE15
      st_next.active = 1'b1;
      st_next.addr_ph = 1'b1;
      st_next.bitcnt = `I2CC_BIT_PRE;
      st_next.addressed = 1'b0;
      st_next.xmit = st_reg.is_master;
      st_next.byte_done = 1'b0;
      st_next.rx_nack = 1'b0;
      // a master keeps data low until the clock has fallen
      st_next.sda_drv = st_reg.is_master; // RULE3
    end else if (stop_det) begin
      st_next.busy = 1'b0; // RULE15
      st_next.active = 1'b0;
      st_next.addressed = 1'b0;
      st_next.sda_drv = 1'b0;
    end else if (st_reg.active && rise && !st_reg.bitcnt[3]) begin
      st_next.rx_sh = {st_reg.rx_sh[6:0], sda_s}; // RULE5
      if (st_reg.bitcnt == `I2CC_BIT_FIRST) begin
        st_next.byte_done = 1'b0; // RULE21
      end
    end else if (st_reg.active && rise && st_reg.bitcnt == `I2CC_BIT_ACK) begin
      st_next.rx_nack = st_reg.xmit & sda_s;
      if (!st_reg.is_master && st_reg.xmit && sda_s) begin
        st_next.xmit = 1'b0; // RULE8
      end
    end else if (st_reg.active && fall) begin
      if (st_reg.bitcnt == `I2CC_BIT_PRE) begin
        st_next.bitcnt = `I2CC_BIT_FIRST;
      end else if (st_reg.bitcnt == `I2CC_BIT_LAST) begin
        st_next.bitcnt = `I2CC_BIT_ACK; // RULE4
        if (st_reg.addr_ph) begin
          st_next.rw_bit = st_reg.rx_sh[0]; // RULE9
          if (!st_reg.is_master && st_reg.rx_sh[7:1] == own_addr) begin
            st_next.addressed = 1'b1; // RULE10
            st_next.hit_flag = 1'b1; // RULE13
          end else if (!st_reg.is_master) begin
            st_next.active = 1'b0;
          end
        end else if (!st_reg.xmit) begin
          st_next.rx_byte = st_reg.rx_sh;
        end
      end else if (st_reg.bitcnt == `I2CC_BIT_ACK) begin
        st_next.bitcnt = `I2CC_BIT_FIRST;
        st_next.addr_ph = 1'b0;
        if (st_reg.is_master || st_reg.addressed) begin
          st_next.byte_done = 1'b1; // RULE21
        end
        if (st_reg.addr_ph) begin
          st_next.xmit = st_reg.is_master ? ~st_reg.rw_bit : st_reg.rw_bit; // RULE9
        end
      end else begin
        st_next.bitcnt = st_reg.bitcnt + 4'h1;
      end
      // the line for the coming bit is set just after the clock fell
      if (st_next.bitcnt == `I2CC_BIT_ACK) begin
        st_next.sda_drv = ~st_next.xmit & (st_next.is_master | st_next.addressed) &
                          (st_reg.addr_ph | ~ack_disable); // RULE6 RULE14
      end else begin
        st_next.sda_drv = st_next.xmit & (st_next.is_master | st_next.addressed) &
                          ~st_reg.tx_byte[~st_next.bitcnt[2:0]]; // RULE3 RULE5
      end
    end

    // master clock generator
    if (arb_hit) begin
      st_next.ms = M_IDLE; // RULE12
      st_next.is_master = 1'b0;
      st_next.arb_flag = 1'b1;
      st_next.cnt = '0;
    end else begin
      unique case (st_reg.ms)
        M_IDLE: begin
          st_next.cnt = '0;
          if (master_sel && st_reg.go && !st_reg.busy && scl_s && sda_s) begin
            st_next.ms = M_START; // RULE15
            st_next.is_master = 1'b1;
            st_next.go = 1'b0;
          end
        end
        M_START: begin
          st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
          if (half_done) begin
            st_next.ms = M_LOW; // RULE1
          end
        end
        M_LOW: begin
          st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
          if (half_done) begin
            st_next.ms = M_HIGH; // RULE22
          end
        end
        M_HIGH: begin
          // another master pulling the clock low shortens our high phase
          if (fall) begin
            st_next.ms = M_LOW;
            st_next.cnt = '0;
          end else if (scl_s) begin
            st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
            if (half_done) begin
              st_next.ms = (st_reg.bitcnt == `I2CC_BIT_ACK) ? M_HOLD : M_LOW;
            end
          end
        end
        M_HOLD: begin
          // clock held low until the host decides how to continue
          st_next.cnt = '0;
          if (st_reg.byte_done) begin
            if (st_reg.rx_nack || !master_sel) begin
              st_next.ms = M_STOP1; // RULE7
              // a stale data bit left driving would block the stop forever
              st_next.sda_drv = 1'b0;
            end else if (repeat_start && st_reg.go) begin
              st_next.ms = M_RS1; // RULE11
              st_next.go = 1'b0;
              st_next.sda_drv = 1'b0;
            end else if (st_reg.go) begin
              st_next.ms = M_LOW;
              st_next.go = 1'b0;
              // first bit was picked at the ninth fall, before the host loaded this byte
              st_next.sda_drv = st_reg.xmit & ~st_reg.tx_byte[7]; // RULE3 RULE5
            end
          end
        end
        M_STOP1: begin
          st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
          if (half_done) begin
            st_next.ms = M_STOP2;
          end
        end
        M_STOP2: begin
          if (scl_s) begin
            st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
            if (half_done) begin
              st_next.ms = M_IDLE; // RULE2 RULE11
              st_next.is_master = 1'b0;
            end
          end
        end
        M_RS1: begin
          st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
          if (half_done) begin
            st_next.ms = M_RS2;
          end
        end
        M_RS2: begin
          if (scl_s) begin
            st_next.cnt = half_done ? '0 : st_reg.cnt + 1'b1;
            if (half_done) begin
              st_next.ms = M_START; // RULE11
            end
          end
        end
      endcase
    end

    // host strobe port; last so that a host access wins over consumption
    unique case (st_reg.hs)
      H_IDLE: begin
        if (!as_s) begin
          st_next.hs = H_ADDR; // RULE16
        end
      end
      H_ADDR: begin
        if (as_s) begin
          st_next.hs = H_IDLE;
        end else if (!ds_s && host_addr[23:8] == BASE_ADDR) begin
          st_next.hs = H_XFER; // RULE17
        end
      end
      H_XFER: begin
        st_next.hs = H_ACK;
        st_next.go = 1'b1;
        if (rw_s) begin
          st_next.dout = st_reg.rx_byte; // RULE18
          st_next.dout_oe = 1'b1;
        end else begin
          st_next.tx_byte = host_data_in;
        end
      end
      H_ACK: begin
        if (as_s && ds_s) begin
          st_next.hs = H_IDLE; // RULE23
          st_next.dout_oe = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = (st_reg.ms == M_LOW) | (st_reg.ms == M_HOLD) | (st_reg.ms == M_STOP1) |
                  (st_reg.ms == M_RS1);
  always_comb begin
    unique case (st_reg.ms)
      M_START, M_STOP1, M_STOP2: sda_oe = 1'b1; // RULE1 RULE2
      M_RS1, M_RS2: sda_oe = 1'b0; // RULE11
      default: sda_oe = st_reg.sda_drv;
    endcase
  end
  assign host_data_out = st_reg.dout;
  assign host_data_oe = st_reg.dout_oe;
  assign transfer_ack_n = ~(st_reg.hs == H_ACK); // RULE19
  assign irq_n = ~(irq_enable & (st_reg.byte_done | st_reg.arb_flag | st_reg.hit_flag)); // RULE20
  assign byte_done_flag = st_reg.byte_done;
  assign bus_busy = st_reg.busy;
  assign master_mode = st_reg.is_master;
  assign slave_addressed = st_reg.addressed;
  assign slave_read = st_reg.rw_bit;
  assign arb_lost = st_reg.arb_flag;
  assign addressed_hit = st_reg.hit_flag;
  assign rx_nack = st_reg.rx_nack;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_acked;
    (st_reg.hs == H_ACK) ##1 (as_s && ds_s);
  endsequence
  sequence s_addr_match;
    st_reg.active && fall && st_reg.addr_ph && !st_reg.is_master &&
      (st_reg.bitcnt == `I2CC_BIT_LAST) && (st_reg.rx_sh[7:1] == own_addr);
  endsequence

  a_start_busy: assert property (start_det |=> st_reg.busy && st_reg.bitcnt == `I2CC_BIT_PRE) // RULE1
    else $error("start not tracked");
  a_stop_free: assert property (stop_det |=> !st_reg.busy && !st_reg.active) // RULE2
    else $error("stop did not free the bus");
  a_sda_stable: assert property ((st_reg.ms == M_HIGH) && $past(st_reg.ms == M_HIGH) |-> $stable(sda_oe)) // RULE3
    else $error("data changed while clock high");
  a_ninth_fall: assert property (st_reg.active && fall && st_reg.bitcnt == `I2CC_BIT_ACK && // RULE21
    (st_reg.is_master || st_reg.addressed) |=> byte_done_flag && st_reg.bitcnt == `I2CC_BIT_FIRST)
    else $error("byte done not set on ninth clock");
  a_msb_first: assert property (st_reg.active && rise && !st_reg.bitcnt[3] && !start_det && // RULE5
    !stop_det |=> st_reg.rx_sh[0] == $past(sda_s) && st_reg.rx_sh[7:1] == $past(st_reg.rx_sh[6:0]))
    else $error("receive shift order wrong");
  a_ack_release: assert property ((st_reg.bitcnt == `I2CC_BIT_ACK) && st_reg.xmit |-> !st_reg.sda_drv) // RULE6
    else $error("transmitter drove acknowledge slot");
  a_nack_stop: assert property ((st_reg.ms == M_HOLD) && st_reg.byte_done && st_reg.rx_nack && // RULE7
    !arb_hit |=> st_reg.ms == M_STOP1)
    else $error("no stop after not-acknowledge");
  a_slave_release: assert property (st_reg.active && rise && st_reg.bitcnt == `I2CC_BIT_ACK && // RULE8
    !st_reg.is_master && st_reg.xmit && sda_s && !start_det && !stop_det |=> !st_reg.xmit)
    else $error("slave transmitter kept the line");
  a_addr_hit: assert property (s_addr_match |=> st_reg.addressed && st_reg.hit_flag && // RULE13
    st_reg.sda_drv && st_reg.bitcnt == `I2CC_BIT_ACK)
    else $error("own address not answered");
  a_arb_switch: assert property (arb_hit |=> !master_mode && arb_lost && st_reg.ms == M_IDLE) // RULE12
    else $error("lost arbitration not handled");
  a_low_time: assert property ((st_reg.ms == M_LOW) && half_done && !arb_hit |=> st_reg.ms == M_HIGH // RULE22
    ##1 !scl_oe)
    else $error("clock low phase wrong length");
  a_xfer_ack: assert property ((st_reg.hs == H_XFER) |=> !transfer_ack_n && // RULE19
    (host_data_oe == $past(rw_s)))
    else $error("acknowledge missing after transfer");
  a_ack_drop: assert property (s_acked |=> (st_reg.hs == H_IDLE) && transfer_ack_n && !host_data_oe) // RULE23
    else $error("acknowledge not withdrawn");
endmodule

// >>> testbench/i2cc_peer_model.sv
// behavioural slave on the far side of the two-wire bus
`timescale 1ns/1ps
module i2cc_peer_model #(
  parameter logic [6:0] ADDR = 7'h3A,
  parameter logic [7:0] TX = 8'hC3
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  output logic [7:0] rx_last,
  output logic nack_seen
);
  logic [7:0] b;
  task automatic get_byte();
    repeat (8) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask
  // moves only well after the falling clock, never while the clock is high
  task automatic drive(input logic v);
    @(negedge scl);
    #40 sda_pull = v;
  endtask
  initial begin
    sda_pull = 1'b0;
    rx_last = 8'h00;
    nack_seen = 1'b0;
    b = 8'h00;
    forever begin
      @(negedge sda iff scl === 1'b1);
      get_byte();
      if (b[7:1] == ADDR) begin
        drive(1'b1);
        if (b[0]) begin
          for (int i = 7; i >= 0; i--) begin
            drive(~TX[i]);
          end
          drive(1'b0);
          @(posedge scl);
          nack_seen = sda;
        end else begin
          drive(1'b0);
          get_byte();
          rx_last = b;
          drive(1'b1);
          drive(1'b0);
        end
      end
    end
  end
endmodule

// >>> testbench/i2cc_ctrl_tb.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
module i2cc_ctrl_tb;
  localparam logic [6:0] PEER = 7'h3A;
  localparam logic [23:0] BASE = 24'h001000;
  logic clock, reset_n, scl_out, scl_oe, sda_out, sda_oe, host_data_oe, address_strobe_n, data_strobe_n;
  logic read_write, transfer_ack_n, irq_n, byte_done_flag, master_sel, repeat_start, ack_disable;
  logic irq_enable, flag_clear, bus_busy, master_mode, slave_addressed, slave_read, arb_lost;
  logic addressed_hit, rx_nack, tb_scl_low, tb_sda_low, peer_pull, peer_nack, scl_w, sda_w, a;
  logic [23:0] host_addr;
  logic [7:0] host_data_in, host_data_out, peer_rx, q;
  logic [6:0] own_addr;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  // open-drain lines with pull-ups
  assign scl_w = ~(scl_oe | tb_scl_low);
  assign sda_w = ~(sda_oe | peer_pull | tb_sda_low);
  i2cc_ctrl #(.CLK_KHZ(1600), .SCL_KHZ(100)) dut (.clock, .reset_n, .scl_in(scl_w), .scl_out, .scl_oe,
    .sda_in(sda_w), .sda_out, .sda_oe, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
    .address_strobe_n, .data_strobe_n, .read_write, .transfer_ack_n, .irq_n, .byte_done_flag, .master_sel,
    .repeat_start, .ack_disable, .own_addr, .irq_enable, .flag_clear, .bus_busy, .master_mode,
    .slave_addressed, .slave_read, .arb_lost, .addressed_hit, .rx_nack);
  i2cc_peer_model #(.ADDR(PEER), .TX(8'hC3)) peer (.scl(scl_w), .sda(sda_w), .sda_pull(peer_pull),
    .rx_last(peer_rx), .nack_seen(peer_nack));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic host(input logic rw, input logic [23:0] ad, input logic [7:0] d, output logic ok);
    ok = 1'b0;
    @(negedge clock);
    host_addr = ad;
    read_write = rw;
    host_data_in = d;
    address_strobe_n = 1'b0;
    data_strobe_n = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clock);
      if (transfer_ack_n === 1'b0) begin
        ok = 1'b1;
        q = host_data_out;
        if (rw) check("data enable", {7'h00, host_data_oe}, 8'h01);
      end
    end
    @(negedge clock);
    address_strobe_n = 1'b1;
    data_strobe_n = 1'b1;
    cyc(8);
    check("ack release", {6'h00, transfer_ack_n, host_data_oe}, 8'h02);
  endtask
  task automatic wr(input logic [7:0] d);
    host(1'b0, BASE, d, a);
    check("write ack", {7'h00, a}, 8'h01);
  endtask
  task automatic rd();
    host(1'b1, BASE, 8'h00, a);
    check("read ack", {7'h00, a}, 8'h01);
  endtask
  task automatic next_byte();
    for (int i = 0; i < 400 && byte_done_flag !== 1'b0; i++) @(negedge clock);
    cyc(40);
    check("done clear", {7'h00, byte_done_flag}, 8'h00);
    for (int i = 0; i < 400 && byte_done_flag !== 1'b1; i++) @(negedge clock);
    check("done set", {7'h00, byte_done_flag}, 8'h01);
  endtask
  task automatic wait_free();
    for (int i = 0; i < 600 && bus_busy !== 1'b0; i++) @(negedge clock);
  endtask
  // external master: each phase 20 system clocks
  task automatic ext_bit(input logic v, output logic s);
    // data moves only once the falling clock has settled
    cyc(2);
    tb_sda_low = ~v;
    cyc(18);
    tb_scl_low = 1'b0;
    cyc(20);
    s = sda_w;
    tb_scl_low = 1'b1;
  endtask
  task automatic ext_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      ext_bit(d[i], ack);
    end
    ext_bit(1'b1, ack);
  endtask
  task automatic t_master();
    wr({PEER, 1'b0});
    master_sel = 1'b1;
    next_byte();
    check("master busy", {5'h00, bus_busy, master_mode, rx_nack}, 8'h06);
    check("done irq", {7'h00, irq_n}, 8'h00);
    wr(8'hA5);
    next_byte();
    check("peer data", peer_rx, 8'hA5);
    repeat_start = 1'b1;
    wr({PEER, 1'b1});
    next_byte();
    repeat_start = 1'b0;
    check("no stop", {6'h00, slave_read, bus_busy}, 8'h03);
    ack_disable = 1'b1;
    rd();
    next_byte();
    // drop master request first so the final read does not clock another byte
    master_sel = 1'b0;
    rd();
    check("read byte", q, 8'hC3);
    check("final nack", {7'h00, peer_nack}, 8'h01);
    ack_disable = 1'b0;
    wait_free();
    check("stopped", {5'h00, bus_busy, scl_w, sda_w}, 8'h03);
  endtask
  task automatic t_nack();
    wr({7'h11, 1'b0});
    master_sel = 1'b1;
    for (int i = 0; i < 600 && bus_busy !== 1'b1; i++) @(negedge clock);
    wait_free();
    check("auto stop", {6'h00, rx_nack, bus_busy}, 8'h02);
    master_sel = 1'b0;
  endtask
  task automatic t_slave();
    tb_sda_low = 1'b1;
    cyc(20);
    tb_scl_low = 1'b1;
    ext_byte({7'h2C, 1'b0}, a);
    check("slave ack", {7'h00, a}, 8'h00);
    check("addressed", {4'h0, slave_read, addressed_hit, slave_addressed, irq_n}, 8'h06);
    ext_byte(8'h96, a);
    check("data ack", {7'h00, a}, 8'h00);
    tb_sda_low = 1'b1;
    cyc(20);
    tb_scl_low = 1'b0;
    cyc(20);
    tb_sda_low = 1'b0;
    cyc(20);
    check("ext free", {7'h00, bus_busy}, 8'h00);
    rd();
    check("slave rx", q, 8'h96);
    flag_clear = 1'b1;
    cyc(1);
    flag_clear = 1'b0;
    cyc(2);
    check("hit clear", {7'h00, addressed_hit}, 8'h00);
  endtask
  task automatic t_arb();
    wr({7'h5A, 1'b0});
    master_sel = 1'b1;
    for (int i = 0; i < 600 && scl_w !== 1'b0; i++) @(negedge clock);
    cyc(2);
    // another master holds data low where this one sends a one
    tb_sda_low = 1'b1;
    for (int i = 0; i < 100 && arb_lost !== 1'b1; i++) @(negedge clock);
    check("arb lost", {5'h00, arb_lost, master_mode, irq_n}, 8'h04);
    master_sel = 1'b0;
    cyc(30);
    tb_sda_low = 1'b0;
    cyc(20);
    check("arb free", {6'h00, bus_busy, scl_w}, 8'h01);
  endtask
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    host_addr = 24'h000000;
    host_data_in = 8'h00;
    address_strobe_n = 1'b1;
    data_strobe_n = 1'b1;
    read_write = 1'b1;
    master_sel = 1'b0;
    repeat_start = 1'b0;
    ack_disable = 1'b0;
    own_addr = 7'h2C;
    irq_enable = 1'b1;
    flag_clear = 1'b0;
    tb_scl_low = 1'b0;
    tb_sda_low = 1'b0;
    q = 8'h00;
    cyc(8);
    reset_n = 1'b1;
    check("reset outs", {scl_out, sda_out, transfer_ack_n, irq_n, host_data_oe, bus_busy, sda_oe, scl_oe},
      8'h30);
    host(1'b0, 24'hABCD00, 8'h00, a);
    check("refused", {7'h00, a}, 8'h00);
    t_master();
    t_nack();
    t_slave();
    t_arb();
    conclude();
  end
endmodule
